// ### pmesc_counter_props.sv
// pmesc_counter_props: bus handshake timing checks for pmesc_counter_top
// Assumes only the top's ports; counters are seen by the bench through reads
`timescale 1ns/1ns
`default_nettype none
module pmesc_counter_props
  import pmesc_pkg::*;
(
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Write side
  input wire logic          awvalid,
  input wire logic          awready,
  input wire logic          wvalid,
  input wire logic          wready,
  input wire logic          bvalid,
  input wire logic          bready,
  input wire logic [1:0]    bresp,
  // Read side
  input wire logic          arvalid,
  input wire logic          arready,
  input wire logic          rvalid,
  input wire logic          rready,
  input wire logic [CW-1:0] rdata,
  input wire logic [1:0]    rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_lat;
    awvalid && awready && wvalid && wready && !bvalid |=> !bvalid ##1 bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_aw_block;
    awvalid && awready |=> !awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("second write taken");
  property p_b_done;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  property p_ready_back;
    $rose(bvalid) |-> awready && wready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back");
  property p_rd_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer stuck");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");

  c_write: cover property (bvalid && bready);
  c_stall: cover property (rvalid && !rready);
  c_slverr: cover property (rvalid && rready && rresp == RESP_SLVERR);
  c_wr_err: cover property (bvalid && bready && bresp == RESP_SLVERR);
endmodule

bind pmesc_counter_top pmesc_counter_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp)
);
`default_nettype wire

// ### pmesc_counter_top.sv
// pmesc_counter_top: eight selectable event counters behind AXI4-Lite
// Assumes one clock, pipeline events synchronous to aclk, AXI4-Lite master
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Select code all ones stops that counter completely.
// - Code zero adds one every cycle while monitoring is enabled.
// - Cycle counting obeys the user and supervisor select bits.
// - Code one adds the committed instruction count per cycle.
// - Code 0x08 counts committed loads, stores and atomics.
// - Code 0x09 counts committed branches, calls, jumps and returns.
// - Code 0x0a counts committed float operations except fused multiply-add.
// - Code 0x0b counts only committed fused multiply-add instructions.
// - Code 0x0c counts committed software prefetches.
// - All-traps event counts every taken trap, equalling the per-kind sum.
// - Trap code gives per-position trap kinds in fixed counter order.
// - Issue events count speculatively; cycle, empty-buffer and zero-issue events count cycles; others count committed work.
// - Code 0x02 on upper counters 0 and 2 counts committed micro-ops.
// - Code 0x03 on upper counters 0 and 2 counts empty issue buffer cycles.
// - Re-fetch event counts commit-time re-fetches of any cause.
// - Flush event counts each mispredict pipeline flush once.
// - Zero-issue event counts cycles issuing no micro-op.
// - Issue events count cycles issuing exactly one to four micro-ops.
module pmesc_counter_top
  import pmesc_pkg::*;
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Write address channel
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  // Write data channel
  input  wire logic [CW-1:0] wdata,
  input  wire logic [SW-1:0] wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // Write response channel
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // Read address channel
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  // Read data channel
  output logic [CW-1:0]      rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // Pipeline events
  input  wire pmesc_event_s  ev
);

  function automatic logic word_is(input logic [AW-1:0] a,
                                   input logic [AW-1:0] b);
    word_is = a[AW-1:IDX_LO] == b[AW-1:IDX_LO];
  endfunction

  function automatic logic blk_is(input logic [AW-1:0] a,
                                  input logic [AW-1:0] b);
    blk_is = a[AW-1:BLK_LO] == b[AW-1:BLK_LO];
  endfunction

  // Slot inside a 32-byte select or counter block
  function automatic pmesc_idx_t slot_of(input logic [AW-1:0] a);
    slot_of = a[IDX_HI:IDX_LO];
  endfunction

  // Counters hit by an access: direct slot or pair window
  function automatic logic [NCNT-1:0] cnt_map(input logic [AW-1:0] a,
                                              input logic [1:0]    pr);
    logic [NCNT-1:0] m;
    m = '0;
    if (blk_is(a, A_CNT_BASE))
      m[slot_of(a)] = 1'b1;
    if (word_is(a, A_WINU))
      m[{pr, 1'b0}] = 1'b1;
    if (word_is(a, A_WINL))
      m[{pr, 1'b1}] = 1'b1;
    cnt_map = m;
  endfunction

  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = word_is(a, A_CTRL) || word_is(a, A_STAT)
           || word_is(a, A_WINU) || word_is(a, A_WINL)
           || blk_is(a, A_SEL_BASE) || blk_is(a, A_CNT_BASE);
  endfunction

  function automatic logic [CW-1:0] strb_merge(input logic [CW-1:0] old,
                                               input logic [CW-1:0] nw,
                                               input logic [SW-1:0] st);
    logic [CW-1:0] r;
    r = old;
    for (int b = 0; b < SW; b++)
    begin
      if (st[b])
        r[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
    end
    strb_merge = r;
  endfunction

  // Register state
  logic [CTRL_W-1:0] ctrl_reg;
  pmesc_code_t       sel_reg [NCNT];
  logic [CW-1:0]     cnt_reg [NCNT];
  logic [NCNT-1:0]   ovf_reg;

  // Bus state
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic [AW-1:0]     aw_addr_reg;
  logic [CW-1:0]     w_data_reg;
  logic [SW-1:0]     w_strb_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [CW-1:0]     rdata_reg;

  // Datapath
  pmesc_inc_t        inc     [NCNT];
  pmesc_sum_t        sum     [NCNT];
  logic [NCNT-1:0]   carry;
  logic              active;
  logic [1:0]        pair;
  logic              do_wr;
  logic [NCNT-1:0]   cnt_wmask;
  logic [NCNT-1:0]   rd_cmask;
  logic [CW-1:0]     rd_data;

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  assign pair = ctrl_reg[CTRL_PAIR_HI:CTRL_PAIR_LO];

  // Privilege gating applies to every event, cycle counts included
  always_comb
  begin
    active = ctrl_reg[CTRL_EN]
          && (ev.supervisor ? ctrl_reg[CTRL_ST] : ctrl_reg[CTRL_UT]);
  end

  // One decoder per position, each seeing only its own select
  genvar g;
  generate
    for (g = 0; g < NCNT; g++)
    begin : g_sel
      pmesc_event_sel u_sel (
        .code (sel_reg[g]),
        .idx  (pmesc_idx_t'(g)),
        .ev   (ev),
        .inc  (inc[g])
      );
    end
  endgenerate

  // Counters that the pending bus write lands on
  always_comb
  begin
    cnt_wmask = do_wr ? cnt_map(aw_addr_reg, pair) : '0;
  end

  always_comb
  begin
    for (int i = 0; i < NCNT; i++)
    begin
      sum[i]   = {1'b0, cnt_reg[i]} + pmesc_sum_t'(inc[i]);
      carry[i] = active && !cnt_wmask[i] && sum[i][CW];
    end
  end

  // Write address and data taken independently; write once both held
  assign do_wr = !awready_reg && !wready_reg && !bvalid_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      aw_addr_reg <= '0;
    end
    else if (awvalid && awready_reg)
    begin
      awready_reg <= 1'b0;
      aw_addr_reg <= awaddr;
    end
    else if (do_wr)
      awready_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_reg <= 1'b1;
      w_data_reg <= ZERO_W;
      w_strb_reg <= '0;
    end
    else if (wvalid && wready_reg)
    begin
      wready_reg <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end
    else if (do_wr)
      wready_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_reg && bready)
      bvalid_reg <= 1'b0;
  end

  // Control and select fields live in byte lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= CTRL_RST;
    else if (do_wr && w_strb_reg[0] && word_is(aw_addr_reg, A_CTRL))
      ctrl_reg <= w_data_reg[CTRL_W-1:0];
  end

  // Selects reset to the disabled code so nothing counts until set up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NCNT; i++)
        sel_reg[i] <= EV_OFF;
    end
    else if (do_wr && w_strb_reg[0] && blk_is(aw_addr_reg, A_SEL_BASE))
      sel_reg[slot_of(aw_addr_reg)] <= w_data_reg[EW-1:0];
  end

  // Software write wins over a same-cycle increment of that counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NCNT; i++)
        cnt_reg[i] <= CNT_RST;
    end
    else
    begin
      for (int i = 0; i < NCNT; i++)
      begin
        if (cnt_wmask[i])
          cnt_reg[i] <= strb_merge(cnt_reg[i], w_data_reg, w_strb_reg);
        else if (active)
          cnt_reg[i] <= sum[i][CW-1:0];
      end
    end
  end

  // Sticky wrap flags, write one to clear; a new wrap beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovf_reg <= '0;
    else if (do_wr && w_strb_reg[0] && word_is(aw_addr_reg, A_STAT))
      ovf_reg <= (ovf_reg & ~w_data_reg[NCNT-1:0]) | carry;
    else
      ovf_reg <= ovf_reg | carry;
  end

  // Counters a read address reaches, windows included
  always_comb
  begin
    rd_cmask = cnt_map(araddr, pair);
  end

  // Read decode
  always_comb
  begin
    rd_data  = ZERO_W;
    if (word_is(araddr, A_CTRL))
      rd_data = CW'(ctrl_reg);
    else if (word_is(araddr, A_STAT))
      rd_data = CW'(ovf_reg);
    else if (blk_is(araddr, A_SEL_BASE))
      rd_data = CW'(sel_reg[slot_of(araddr)]);
    else
    begin
      for (int i = 0; i < NCNT; i++)
      begin
        if (rd_cmask[i])
          rd_data = rd_data | cnt_reg[i];
      end
    end
  end

  // One read in flight; a new address waits for rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arready_reg <= 1'b1;
    else if (arvalid && arready_reg)
      arready_reg <= 1'b0;
    else if (rvalid_reg && rready)
      arready_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= ZERO_W;
    end
    else if (arvalid && arready_reg)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_data;
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
  end

endmodule
`default_nettype wire

// ### pmesc_event_sel.sv
// pmesc_event_sel: decodes one counter's select code into an increment
// Assumes event inputs already settled in the current aclk cycle
`timescale 1ns/1ns
`default_nettype none
module pmesc_event_sel
  import pmesc_pkg::*;
(
  // Selection
  input  wire pmesc_code_t  code,
  input  wire pmesc_idx_t   idx,
  // Events
  input  wire pmesc_event_s ev,
  // Increment
  output pmesc_inc_t        inc
);

  function automatic pmesc_inc_t b2i(input logic b);
    b2i = b ? INC_ONE : INC_NONE;
  endfunction

  function automatic pmesc_trap_e trap_of(input pmesc_idx_t i);
    case (i)
      IX_L0:   trap_of = TRK_VECT;
      IX_U1:   trap_of = TRK_LEVEL;
      IX_L1:   trap_of = TRK_SPILL;
      IX_U2:   trap_of = TRK_FILL;
      IX_L2:   trap_of = TRK_TCC;
      IX_U3:   trap_of = TRK_ITRANS;
      default: trap_of = TRK_DTRANS;
    endcase
  endfunction

  logic upper_even;

  always_comb
  begin
    upper_even = (idx == IX_U0) || (idx == IX_U2);
    inc = INC_NONE;
    case (code)
      EV_CYCLE:   inc = INC_ONE;
      EV_INSN:    inc = pmesc_inc_t'(ev.commit_insn);
      EV_UOP:     inc = upper_even ? ev.commit_uop : INC_NONE;
      EV_IBUF:    inc = b2i(upper_even && ev.issue_buf_empty);
      EV_LDST:    inc = pmesc_inc_t'(ev.commit_ldst);
      EV_BRANCH:  inc = pmesc_inc_t'(ev.commit_branch);
      EV_FPOP:    inc = pmesc_inc_t'(ev.commit_fpop);
      EV_FMA:     inc = pmesc_inc_t'(ev.commit_fma);
      EV_PREF:    inc = pmesc_inc_t'(ev.commit_pref);
      EV_REFETCH:
      begin
        if (idx == IX_U0)
          inc = b2i(ev.commit_refetch);
        else if (idx == IX_L0)
          inc = b2i(ev.mispredict_flush);
      end
      EV_ISSUE:
      begin
        // Issue counts are speculative, taken at the issue stage
        if (idx <= IX_L1)
          inc = b2i(ev.issue_uop == 3'(idx + 3'h1));
      end
      EV_ALT:
      begin
        if (idx == IX_L1)
          inc = b2i(ev.mispredict_flush);
        else if (idx == IX_U3)
          inc = b2i(ev.commit_refetch);
      end
      EV_TRAP:
      begin
        if (idx == IX_U0)
          inc = b2i(ev.trap_taken);
        else
          inc = b2i(ev.trap_taken && ev.trap_kind == trap_of(idx));
      end
      EV_MISC:
      begin
        if (idx == IX_L1)
          inc = b2i(ev.issue_uop == ISSUE_NONE);
        else if (idx == IX_U2)
          inc = b2i(ev.mispredict_flush);
      end
      EV_OFF:     inc = INC_NONE;
      default:    inc = INC_NONE;
    endcase
  end

endmodule
`default_nettype wire

// ### pmesc_pipe_model.sv
// pmesc_pipe_model: pipeline stand-in giving bursts of event cycles
// Assumes the bench picks the pattern and burst length
`timescale 1ns/1ns
`default_nettype none
module pmesc_pipe_model
  import pmesc_pkg::*;
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Burst control
  input  wire logic         go,
  input  wire logic [7:0]   len,
  input  wire logic         hold_sup,
  input  wire pmesc_event_s pat,
  // Events
  output pmesc_event_s      ev,
  output logic              busy
);
  logic [7:0] left_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      left_reg <= 8'h00;
    else if (go)
      left_reg <= len;
    else if (busy)
      left_reg <= left_reg - 8'h01;
  end

  // Idle drives the mode from hold_sup, so bus traffic counts only if that mode is enabled
  always_comb
  begin
    ev = '0;
    ev.supervisor = hold_sup;
    if (busy)
      ev = pat;
  end

  assign busy = left_reg != 8'h00;
endmodule
`default_nettype wire

// ### pmesc_pkg.sv
// pmesc_pkg: constants, codes, register map and event carrier
// Assumes AXI4-Lite with 32-bit data and a 12-bit byte address
package pmesc_pkg;

  localparam int NCNT   = 8;
  localparam int CW     = 32;
  localparam int AW     = 12;
  localparam int EW     = 6;
  localparam int IW     = 4;
  localparam int SW     = 4;
  localparam int BYTE_W = 8;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 4;
  localparam int BLK_LO = 5;

  typedef logic [EW-1:0] pmesc_code_t;
  typedef logic [IW-1:0] pmesc_inc_t;
  typedef logic [CW:0]   pmesc_sum_t;
  typedef logic [2:0]    pmesc_idx_t;

  // Event select codes
  localparam pmesc_code_t EV_CYCLE   = 6'h00;
  localparam pmesc_code_t EV_INSN    = 6'h01;
  localparam pmesc_code_t EV_UOP     = 6'h02;
  localparam pmesc_code_t EV_IBUF    = 6'h03;
  localparam pmesc_code_t EV_LDST    = 6'h08;
  localparam pmesc_code_t EV_BRANCH  = 6'h09;
  localparam pmesc_code_t EV_FPOP    = 6'h0a;
  localparam pmesc_code_t EV_FMA     = 6'h0b;
  localparam pmesc_code_t EV_PREF    = 6'h0c;
  localparam pmesc_code_t EV_REFETCH = 6'h12;
  localparam pmesc_code_t EV_ISSUE   = 6'h13;
  localparam pmesc_code_t EV_ALT     = 6'h15;
  localparam pmesc_code_t EV_TRAP    = 6'h16;
  localparam pmesc_code_t EV_MISC    = 6'h1b;
  localparam pmesc_code_t EV_OFF     = 6'h3f;

  // Counter positions: upper then lower of each pair
  localparam pmesc_idx_t IX_U0 = 3'h0;
  localparam pmesc_idx_t IX_L0 = 3'h1;
  localparam pmesc_idx_t IX_U1 = 3'h2;
  localparam pmesc_idx_t IX_L1 = 3'h3;
  localparam pmesc_idx_t IX_U2 = 3'h4;
  localparam pmesc_idx_t IX_L2 = 3'h5;
  localparam pmesc_idx_t IX_U3 = 3'h6;
  localparam pmesc_idx_t IX_L3 = 3'h7;

  localparam pmesc_inc_t INC_ONE  = 4'h1;
  localparam pmesc_inc_t INC_NONE = 4'h0;
  localparam logic [2:0] ISSUE_NONE = 3'h0;

  // Register map (byte addresses)
  localparam logic [AW-1:0] A_CTRL     = 12'h000;
  localparam logic [AW-1:0] A_STAT     = 12'h004;
  localparam logic [AW-1:0] A_WINU     = 12'h008;
  localparam logic [AW-1:0] A_WINL     = 12'h00c;
  localparam logic [AW-1:0] A_SEL_BASE = 12'h020;
  localparam logic [AW-1:0] A_CNT_BASE = 12'h040;

  // Control fields
  localparam int CTRL_W       = 5;
  localparam int CTRL_EN      = 0;
  localparam int CTRL_UT      = 1;
  localparam int CTRL_ST      = 2;
  localparam int CTRL_PAIR_LO = 3;
  localparam int CTRL_PAIR_HI = 4;

  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [CW-1:0]     CNT_RST  = 32'h0000_0000;
  localparam logic [CW-1:0]     ZERO_W   = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TRK_VECT   = 3'b000,
    TRK_LEVEL  = 3'b001,
    TRK_SPILL  = 3'b010,
    TRK_FILL   = 3'b011,
    TRK_TCC    = 3'b100,
    TRK_ITRANS = 3'b101,
    TRK_DTRANS = 3'b110
  } pmesc_trap_e;

  typedef struct packed {
    logic        supervisor;
    logic [2:0]  commit_insn;
    logic [3:0]  commit_uop;
    logic [2:0]  commit_ldst;
    logic [2:0]  commit_branch;
    logic [2:0]  commit_fpop;
    logic [2:0]  commit_fma;
    logic [2:0]  commit_pref;
    logic        trap_taken;
    pmesc_trap_e trap_kind;
    logic        commit_refetch;
    logic        mispredict_flush;
    logic [2:0]  issue_uop;
    logic        issue_buf_empty;
  } pmesc_event_s;

endpackage

// ### testbench.sv
// testbench: register-level tests of pmesc_counter_top
// Assumes pmesc_pipe_model as event source and the bound bus checker
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pmesc_pkg::*;
;
  logic          aclk, aresetn, go, hold_sup, busy;
  logic [AW-1:0] awaddr, araddr;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic [CW-1:0] wdata, rdata, got;
  logic [SW-1:0] wstrb, strb_r;
  logic [1:0]    bresp, rresp, rs;
  logic [7:0]    len_r;
  pmesc_event_s  ev, pat_r, p;
  pmesc_code_t   cs [8];
  int unsigned   m [8];
  int            fail_count, samples_checked;

  pmesc_counter_top dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ev(ev)
  );
  pmesc_pipe_model u_pipe (
    .aclk(aclk), .aresetn(aresetn), .go(go), .len(len_r), .hold_sup(hold_sup),
    .pat(pat_r), .ev(ev), .busy(busy)
  );

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic axi_wr(input logic [AW-1:0] a, input logic [CW-1:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_r;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    // bready stays high between writes, and every write drives it high again
  endtask

  // Read answer is stalled one cycle to exercise the hold rule
  task automatic axi_rd(input logic [AW-1:0] a, output logic [CW-1:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic check(input logic [CW-1:0] g, input logic [CW-1:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One burst of six event cycles from the pipeline stand-in
  task automatic burst(input pmesc_event_s ps);
    pat_r <= ps;
    len_r <= 8'h06;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy);
  endtask

  // Clears and selects all counters, runs six event cycles, reads back
  task automatic run_case(input logic [4:0] ctrl, input pmesc_code_t c [8],
                          input pmesc_event_s ps, input int unsigned k [8]);
    hold_sup <= ctrl[CTRL_UT];
    for (int i = 0; i < NCNT; i++)
    begin
      axi_wr(A_SEL_BASE + 12'(4 * i), {26'h000_0000, c[i]}, rs);
      axi_wr(A_CNT_BASE + 12'(4 * i), ZERO_W, rs);
    end
    axi_wr(A_CTRL, {27'h000_0000, ctrl}, rs);
    burst(ps);
    axi_wr(A_CTRL, ZERO_W, rs);
    for (int i = 0; i < NCNT; i++)
    begin
      axi_rd(A_CNT_BASE + 12'(4 * i), got, rs);
      check(got, 32'(k[i] * 6));
    end
    $display("case with control %h done", ctrl);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    {aresetn, go, hold_sup, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, wstrb, len_r} = '0;
    pat_r = '0;
    strb_r = 4'hf;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(A_SEL_BASE, got, rs);
    check(got, 32'h0000_003f);
    axi_rd(A_CNT_BASE + 12'h01c, got, rs);
    check(got, CNT_RST);
    axi_rd(12'h100, got, rs);
    check({got[31:2], rs}, {30'h0000_0000, RESP_SLVERR});
    axi_wr(12'h100, 32'h0000_0001, rs);
    check({30'h0000_0000, rs}, {30'h0000_0000, RESP_SLVERR});
    $display("reset test done");
    p = '0;
    p.commit_insn = 3'h3;
    p.commit_uop = 4'h5;
    p.commit_ldst = 3'h2;
    p.commit_branch = 3'h1;
    p.commit_fpop = 3'h3;
    p.commit_fma = 3'h2;
    p.commit_pref = 3'h1;
    p.issue_uop = 3'h2;
    p.issue_buf_empty = 1'b1;
    cs = '{EV_INSN, EV_LDST, EV_BRANCH, EV_FPOP, EV_FMA, EV_PREF, EV_OFF, EV_UOP};
    run_case(5'h03, cs, p, '{3, 2, 1, 3, 2, 1, 0, 0});
    cs = '{EV_UOP, EV_ISSUE, EV_ISSUE, EV_IBUF, EV_IBUF, EV_ISSUE, EV_CYCLE, 6'h04};
    run_case(5'h03, cs, p, '{5, 1, 0, 0, 1, 0, 1, 0});
    p.supervisor = 1'b1;
    cs = '{default: EV_CYCLE};
    run_case(5'h05, cs, p, '{default: 1});
    run_case(5'h03, cs, p, '{default: 0});
    run_case(5'h06, cs, p, '{default: 0});
    p = '0;
    p.supervisor = 1'b1;
    p.trap_taken = 1'b1;
    p.trap_kind = TRK_SPILL;
    p.commit_refetch = 1'b1;
    p.mispredict_flush = 1'b1;
    cs = '{EV_REFETCH, EV_REFETCH, EV_REFETCH, EV_MISC, EV_MISC, EV_ALT, EV_ALT, EV_MISC};
    run_case(5'h05, cs, p, '{1, 1, 0, 1, 1, 0, 1, 0});
    for (int k = 0; k < 7; k++)
    begin
      p.trap_kind = pmesc_trap_e'(k);
      m = '{default: 0};
      m[0] = 1;
      m[k + 1] = 1;
      cs = '{default: EV_TRAP};
      run_case(5'h05, cs, p, m);
    end
    // Wrap flag, pair windows, byte strobes and control readback
    hold_sup <= 1'b1;
    axi_wr(A_SEL_BASE, {26'h000_0000, EV_CYCLE}, rs);
    axi_wr(A_CNT_BASE, 32'hffff_fffe, rs);
    axi_wr(A_CTRL, 32'h0000_0013, rs);
    check({30'h0000_0000, rs}, {30'h0000_0000, RESP_OKAY});
    p = '0;
    burst(p);
    axi_rd(A_CNT_BASE, got, rs);
    check(got, 32'h0000_0004);
    axi_rd(A_STAT, got, rs);
    check(got, 32'h0000_0001);
    axi_wr(A_STAT, 32'h0000_0001, rs);
    axi_rd(A_STAT, got, rs);
    check(got, ZERO_W);
    axi_rd(A_CTRL, got, rs);
    check(got, 32'h0000_0013);
    axi_wr(A_WINU, 32'h1234_5678, rs);
    axi_rd(A_CNT_BASE + 12'h010, got, rs);
    check(got, 32'h1234_5678);
    strb_r = 4'h3;
    axi_wr(A_WINL, 32'haabb_ccdd, rs);
    strb_r = 4'hf;
    axi_rd(A_WINL, got, rs);
    check(got, 32'h0000_ccdd);
    $display("wrap and window test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
